// >>> rtl/ccr_ch12_map.vh
// Purpose: offsets, fields and reset values of the ch1/ch2 mode block
// Assumes: byte-addressed 32-bit Wishbone, byte offsets
// Notes:   shared by the design only
`ifndef CCR_CH12_MAP_VH
`define CCR_CH12_MAP_VH
// ==================================================
// register offsets
`define OFS_MODE_CFG    4'h0
`define OFS_ENABLE      4'h4
`define OFS_CMP_VALUE   4'h8
`define OFS_STATUS      4'hC
// ==================================================
// mode register fields
`define F_CH1_DIR_HI    1
`define F_CH1_DIR_LO    0
`define F_CH1_PSC_HI    3
`define F_CH1_PSC_LO    2
`define F_CH1_FLT_HI    7
`define F_CH1_FLT_LO    4
`define F_CH2_DIR_HI    9
`define F_CH2_DIR_LO    8
`define F_CH2_FEN       10
`define F_CH2_PEN       11
`define F_CH2_MOD_HI    14
`define F_CH2_MOD_LO    12
`define F_CH2_CEN       15
`define F_CH2_PSC_HI    11
`define F_CH2_PSC_LO    10
`define F_CH2_FLT_HI    15
`define F_CH2_FLT_LO    12
// ==================================================
// reset values
`define RST_MODE_CFG    16'h0000
`define RST_ENABLE      2'h0
`define RST_CMP_VALUE   16'h0000
`endif

// >>> rtl/ccr_ch12_mode_config.v
// Purpose: mode config, input filter, prescaler, ch2 compare for channels 1-2
// Assumes: 125 MHz clk_i, synchronous active-high reset, classic Wishbone
// Notes:   timer inputs are pins and are synchronised here
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ccr_ch12_map.vh"

module ccr_ch12_mode_config (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire        timer_input_one_i,
  input  wire        timer_input_two_i,
  input  wire        internal_trigger_select_i,
  input  wire        deadtime_sample_clock_i,
  input  wire        ext_trigger_filtered_i,
  input  wire [15:0] counter_value_i,
  input  wire        update_event_i,
  output reg         capture_input_one_o,
  output reg         capture_input_two_o,
  output reg         chan_one_is_input_o,
  output reg         chan_two_is_input_o,
  output reg         chan_two_fast_enable_o,
  output reg         compare_ref_output_o
);

  // ==================================================
  // filter tables
  function [5:0] filt_div;
    input [3:0] code;
    begin
      case (code)
        4'h0, 4'h1, 4'h2, 4'h3: filt_div = 6'h01;
        4'h4, 4'h5:             filt_div = 6'h02;
        4'h6, 4'h7:             filt_div = 6'h04;
        4'h8, 4'h9:             filt_div = 6'h08;
        4'hA:                   filt_div = 6'h10;
        4'hB, 4'hC:             filt_div = 6'h10;
        default:                filt_div = 6'h20;
      endcase
    end
  endfunction

  function [3:0] filt_len;
    input [3:0] code;
    begin
      case (code)
        4'h0:                   filt_len = 4'h1;
        4'h1:                   filt_len = 4'h2;
        4'h2:                   filt_len = 4'h4;
        4'h3, 4'h5, 4'h7, 4'h9: filt_len = 4'h8;
        4'h4, 4'h6, 4'h8:       filt_len = 4'h6;
        4'hA, 4'hD:             filt_len = 4'h5;
        4'hB, 4'hE:             filt_len = 4'h6;
        default:                filt_len = 4'h8;
      endcase
    end
  endfunction

  // ==================================================
  // registers
  reg  [15:0] mode_cfg;
  reg  [1:0]  chan_enable;
  reg  [15:0] cmp_preload;
  reg  [15:0] cmp_active;
  reg         ref_raw;
  reg  [1:0]  in_meta;
  reg  [1:0]  in_sync;

  wire        wb_req;
  wire        wr_lo;
  wire        wr_hi;
  wire        sel_mode;
  wire        sel_enable;
  wire        sel_cmp;
  wire [1:0]  ch1_dir;
  wire [1:0]  ch2_dir;
  wire        ch2_pen;
  wire        ch2_cen;
  wire [2:0]  ch2_mode;
  wire [1:0]  src;
  wire [1:0]  filt_lvl;
  wire [2:0]  psc_cnt0;
  wire [2:0]  psc_cnt1;
  wire [5:0]  psc_all;
  wire [1:0]  cap_evt;

  assign wb_req   = cyc_i & stb_i & ~ack_o;
  assign wr_lo    = wb_req & we_i & sel_i[0];
  assign wr_hi    = wb_req & we_i & sel_i[1];
  assign sel_mode   = (adr_i == `OFS_MODE_CFG);
  assign sel_enable = (adr_i == `OFS_ENABLE);
  assign sel_cmp    = (adr_i == `OFS_CMP_VALUE);
  assign ch1_dir  = mode_cfg[`F_CH1_DIR_HI:`F_CH1_DIR_LO];
  assign ch2_dir  = mode_cfg[`F_CH2_DIR_HI:`F_CH2_DIR_LO];
  assign ch2_pen  = mode_cfg[`F_CH2_PEN];
  assign ch2_cen  = mode_cfg[`F_CH2_CEN];
  assign ch2_mode = mode_cfg[`F_CH2_MOD_HI:`F_CH2_MOD_LO];

  // ==================================================
  // pin synchroniser
  always @(posedge clk_i) begin
    if (rst_i) begin
      in_meta <= 2'h0;
      in_sync <= 2'h0;
    end else if (ce_i) begin
      in_meta <= {timer_input_two_i, timer_input_one_i};
      in_sync <= in_meta;
    end
  end

  // ==================================================
  // input source select
  assign src[0] = (ch1_dir == 2'h1) ? in_sync[0] :
                  (ch1_dir == 2'h2) ? in_sync[1] :
                  (ch1_dir == 2'h3) ?
                  internal_trigger_select_i : 1'b0;
  assign src[1] = (ch2_dir == 2'h1) ? in_sync[1] :
                  (ch2_dir == 2'h2) ? in_sync[0] :
                  (ch2_dir == 2'h3) ?
                  internal_trigger_select_i : 1'b0;

  // ==================================================
  // filter and prescaler, one per channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      reg  [5:0] div_cnt;
      reg  [3:0] agree_cnt;
      reg        level;
      reg        level_d;
      reg  [2:0] psc_cnt;
      reg        cap;
      wire [3:0] fcode;
      wire [1:0] pcode;
      wire [5:0] fdiv;
      wire [3:0] flen;
      wire       tick;
      wire       is_in;
      wire [2:0] psc_top;

      assign fcode = (ch == 0) ? mode_cfg[`F_CH1_FLT_HI:`F_CH1_FLT_LO]
                               : mode_cfg[`F_CH2_FLT_HI:`F_CH2_FLT_LO];
      assign pcode = (ch == 0) ? mode_cfg[`F_CH1_PSC_HI:`F_CH1_PSC_LO]
                               : mode_cfg[`F_CH2_PSC_HI:`F_CH2_PSC_LO];
      assign is_in = (ch == 0) ? (ch1_dir != 2'h0) : (ch2_dir != 2'h0);
      assign fdiv  = filt_div(fcode);
      assign flen  = filt_len(fcode);
      assign tick  = (fcode == 4'h0) ? deadtime_sample_clock_i
                                     : (div_cnt == fdiv - 6'h01);
      assign psc_top = (3'h1 << pcode) - 3'h1;

      always @(posedge clk_i) begin
        if (rst_i) begin
          div_cnt   <= 6'h00;
          agree_cnt <= 4'h0;
          level     <= 1'b0;
        end else if (ce_i) begin
          if (tick || fcode == 4'h0)
            div_cnt <= 6'h00;
          else
            div_cnt <= div_cnt + 6'h01;
          if (tick) begin
            if (src[ch] == level) begin
              agree_cnt <= 4'h0;
            end else if (agree_cnt + 4'h1 >= flen) begin
              level     <= src[ch];
              agree_cnt <= 4'h0;
            end else begin
              agree_cnt <= agree_cnt + 4'h1;
            end
          end
        end
      end

      always @(posedge clk_i) begin
        if (rst_i) begin
          level_d <= 1'b0;
          psc_cnt <= 3'h0;
          cap     <= 1'b0;
        end else if (ce_i) begin
          level_d <= level;
          cap     <= 1'b0;
          if (!is_in || !chan_enable[ch]) begin
            psc_cnt <= 3'h0;
          end else if (level & ~level_d) begin
            if (psc_cnt >= psc_top) begin
              psc_cnt <= 3'h0;
              cap     <= 1'b1;
            end else begin
              psc_cnt <= psc_cnt + 3'h1;
            end
          end
        end
      end

      assign filt_lvl[ch] = level;
      assign psc_all[3 * ch +: 3] = psc_cnt;
      assign cap_evt[ch]  = cap;
    end
  endgenerate

  assign psc_cnt0 = psc_all[2:0];
  assign psc_cnt1 = psc_all[5:3];

  // ==================================================
  // register writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_cfg    <= `RST_MODE_CFG;
      chan_enable <= `RST_ENABLE;
      cmp_preload <= `RST_CMP_VALUE;
    end else if (ce_i) begin
      if (sel_mode) begin
        if (wr_lo) begin
          mode_cfg[7:2] <= dat_i[7:2];
          if (!chan_enable[0])
            mode_cfg[1:0] <= dat_i[1:0];
        end
        if (wr_hi) begin
          mode_cfg[15:10] <= dat_i[15:10];
          if (!chan_enable[1])
            mode_cfg[9:8] <= dat_i[9:8];
        end
      end
      if (sel_enable && wr_lo)
        chan_enable <= dat_i[1:0];
      if (sel_cmp) begin
        if (wr_lo)
          cmp_preload[7:0] <= dat_i[7:0];
        if (wr_hi)
          cmp_preload[15:8] <= dat_i[15:8];
      end
    end
  end

  // ==================================================
  // compare value and reference
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmp_active <= `RST_CMP_VALUE;
    end else if (ce_i) begin
      if (!ch2_pen || update_event_i)
        cmp_active <= cmp_preload;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ref_raw <= 1'b0;
    end else if (ce_i) begin
      case (ch2_mode)
        3'h0: ref_raw <= ref_raw;
        3'h1: if (counter_value_i == cmp_active) ref_raw <= 1'b1;
        3'h2: if (counter_value_i == cmp_active) ref_raw <= 1'b0;
        3'h3: if (counter_value_i == cmp_active) ref_raw <= ~ref_raw;
        3'h4: ref_raw <= 1'b0;
        3'h5: ref_raw <= 1'b1;
        3'h6: ref_raw <= (counter_value_i < cmp_active);
        default: ref_raw <= (counter_value_i > cmp_active);
      endcase
    end
  end

  // ==================================================
  // outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      capture_input_one_o    <= 1'b0;
      capture_input_two_o    <= 1'b0;
      chan_one_is_input_o    <= 1'b0;
      chan_two_is_input_o    <= 1'b0;
      chan_two_fast_enable_o <= 1'b0;
      compare_ref_output_o   <= 1'b0;
    end else if (ce_i) begin
      capture_input_one_o    <= cap_evt[0];
      capture_input_two_o    <= cap_evt[1];
      chan_one_is_input_o    <= (ch1_dir != 2'h0);
      chan_two_is_input_o    <= (ch2_dir != 2'h0);
      chan_two_fast_enable_o <= (ch2_dir == 2'h0) &
                                mode_cfg[`F_CH2_FEN];
      compare_ref_output_o   <= (ch2_dir == 2'h0) & ref_raw &
                                ~(ch2_cen & ext_trigger_filtered_i);
    end
  end

  // ==================================================
  // status word
  wire [31:0] status_word;
  wire        cmp_lo_zero;

  assign cmp_lo_zero = (cmp_active[7:0] == 8'h00);
  assign status_word = {22'h0, cmp_lo_zero, psc_cnt1, psc_cnt0,
                        ref_raw, filt_lvl};

  // ==================================================
  // wishbone answer
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else if (ce_i) begin
      ack_o <= wb_req;
      dat_o <= 32'h00000000;
      if (wb_req && !we_i) begin
        case (adr_i)
          `OFS_MODE_CFG:  dat_o <= {16'h0000, mode_cfg};
          `OFS_ENABLE:    dat_o <= {30'h0, chan_enable};
          `OFS_CMP_VALUE: dat_o <= {16'h0000, cmp_preload};
          `OFS_STATUS:    dat_o <= status_word;
          default:        dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // ccr_ch12_mode_config
`default_nettype wire

// >>> sim/ccr_ch12_mode_config_monitor.sv
// Purpose: port checker for ccr_ch12_mode_config
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the design at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module ccr_ch12_mode_config_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        capture_input_one_o,
  input wire logic        chan_one_is_input_o,
  input wire logic        chan_two_is_input_o,
  input wire logic        chan_two_fast_enable_o,
  input wire logic        compare_ref_output_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // bus and outputs
  AST_ACK: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_ZERO: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  AST_REF_IN: assert property (chan_two_is_input_o [*3] |-> !compare_ref_output_o)
    else $error("reference high while channel two is input");
  AST_FEN_IN: assert property (chan_two_is_input_o [*2] |-> !chan_two_fast_enable_o)
    else $error("fast enable high while channel two is input");
  AST_CAP_PULSE: assert property (capture_input_one_o && ce_i |=> !capture_input_one_o)
    else $error("capture pulse longer than one cycle");
  AST_CAP_DIR: assert property (capture_input_one_o |-> chan_one_is_input_o)
    else $error("capture while channel one is output");
  AST_RST: assert property ($fell(rst_i) |-> !ack_o && !chan_one_is_input_o)
    else $error("outputs not cleared after reset");
  cover property (capture_input_one_o);
  cover property (compare_ref_output_o && !chan_two_is_input_o);
  cover property (ack_o && dat_o != 32'h0);
endmodule // ccr_ch12_mode_config_monitor
bind ccr_ch12_mode_config ccr_ch12_mode_config_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
  .capture_input_one_o(capture_input_one_o), .chan_one_is_input_o(chan_one_is_input_o),
  .chan_two_is_input_o(chan_two_is_input_o), .chan_two_fast_enable_o(chan_two_fast_enable_o),
  .compare_ref_output_o(compare_ref_output_o));
`default_nettype wire

// >>> sim/ccr_ch12_mode_config_tb_top.sv
// Purpose: self-checking bench for ccr_ch12_mode_config
// Assumes: 125 MHz clock, Wishbone classic master in the bench
// Notes:   register model kept in plain variables
`timescale 1ns/1ps
`default_nettype none
module ccr_ch12_mode_config_tb_top;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, tin1 = 0, etr = 0, upd = 0;
  logic [3:0]  adr_i = 0, sel_i = 0;
  logic [31:0] dat_i = 0, rd;
  logic [15:0] cnt = 0, m = 0, cmp = 0;
  logic [1:0]  en = 0;
  logic [2:0]  md;
  logic [3:0]  f;
  logic        ce = 1, tin2 = 0, trg = 0, dts = 1;
  wire  [31:0] dat_o;
  wire         ack_o, cap1, cap2, in1, in2, fen, ref_o;
  integer      n_mismatch = 0, n_tests = 0, c1 = 0, c2 = 0, i, p, v, d;
  ccr_ch12_mode_config u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .timer_input_one_i(tin1), .timer_input_two_i(tin2),
    .internal_trigger_select_i(trg), .deadtime_sample_clock_i(dts),
    .ext_trigger_filtered_i(etr), .counter_value_i(cnt), .update_event_i(upd),
    .capture_input_one_o(cap1), .capture_input_two_o(cap2), .chan_one_is_input_o(in1),
    .chan_two_is_input_o(in2), .chan_two_fast_enable_o(fen), .compare_ref_output_o(ref_o));
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    c1 += cap1;
    c2 += cap2;
  end
  // ==========
  // tasks
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task wb(input [3:0] a, input [31:0] d, input [3:0] s, input w);
    integer k;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    rd = dat_o;
    if (ack_o !== 1'b1) n_mismatch++;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task wr(input [3:0] a, input [15:0] d, input [1:0] s);
    wb(a, {16'h0, d}, {2'b00, s}, 1'b1);
    if (a == 4'h0 && s[0]) m[7:0] = en[0] ? {d[7:2], m[1:0]} : d[7:0];
    if (a == 4'h0 && s[1]) m[15:8] = en[1] ? {d[15:10], m[9:8]} : d[15:8];
    if (a == 4'h4 && s[0]) en = d[1:0];
    if (a == 4'h8) cmp = d;
  endtask
  task rdc(input [3:0] a, input [15:0] e);
    wb(a, 32'h0, 4'hF, 1'b0);
    chk($sformatf("reg %h", a), rd, {16'h0, e});
  endtask
  // source pulse: bit 0 timer input one, bit 1 timer input two, bit 2 trigger
  task pulse(input [2:0] s, input integer w, input integer g);
    {trg, tin2, tin1} <= s;
    repeat (w) @(posedge clk_i);
    {trg, tin2, tin1} <= 3'b000;
    repeat (g) @(posedge clk_i);
  endtask
  // filter divider and length per code
  function automatic integer fdiv_m(input [3:0] c);
    fdiv_m = (c < 4) ? 1 : (c < 10) ? 2 ** ((c - 2) / 2) : (c < 13) ? 16 : 32;
  endfunction
  function automatic integer flen_m(input [3:0] c);
    case (c)
      4'h1:                         flen_m = 2;
      4'h2:                         flen_m = 4;
      4'hA, 4'hD:                   flen_m = 5;
      4'h4, 4'h6, 4'h8, 4'hB, 4'hE: flen_m = 6;
      default:                      flen_m = 8;
    endcase
  endfunction
  task print_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    print_verdict;
  end
  // ==========
  // main sequence
  initial begin
    v = $urandom(93);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(4'h0, 16'h0);
    rdc(4'h4, 16'h0);
    rdc(4'h8, 16'h0);
    rdc(4'h2, 16'h0);
    for (i = 0; i < 12; i++) begin
      v = $urandom;
      if (i == 6) wr(4'h4, 16'h0003, 2'b01);
      wr(4'h0, v[15:0], v[17:16]);
      rdc(4'h0, m);
    end
    wr(4'h4, 16'h0000, 2'b01);
    for (i = 0; i < 4; i++) begin
      wr(4'h0, {6'h0, i[1:0], 6'h0, i[1:0]}, 2'b11);
      repeat (3) @(posedge clk_i);
      chk("in1", in1, i != 0);
      chk("in2", in2, i != 0);
      wr(4'h4, 16'h0003, 2'b01);
      for (p = 0; p < 3; p++) begin
        c1 = 0;
        c2 = 0;
        pulse(3'b001 << p, 4, 12);
        chk("src1", c1, i != 0 && p == i - 1);
        chk("src2", c2, i != 0 && p == (i == 1 ? 1 : i == 2 ? 0 : 2));
      end
      wr(4'h4, 16'h0000, 2'b01);
    end
    for (p = 0; p < 4; p++) begin
      wr(4'h0, {4'h1, p[1:0], 2'b10, 4'h1, p[1:0], 2'b01}, 2'b11);
      wr(4'h4, 16'h0003, 2'b01);
      c1 = 0;
      c2 = 0;
      repeat (8) pulse(3'b001, 10, 10);
      chk("cap1", c1, 8 >> p);
      chk("cap2", c2, 8 >> p);
      wr(4'h4, 16'h0000, 2'b01);
    end
    wr(4'h0, 16'h0001, 2'b11);
    wr(4'h4, 16'h0001, 2'b01);
    c1 = 0;
    dts <= 1'b0;
    pulse(3'b001, 6, 8);
    chk("dts0", c1, 0);
    dts <= 1'b1;
    ce <= 1'b0;
    pulse(3'b001, 6, 8);
    ce <= 1'b1;
    pulse(3'b001, 1, 12);
    chk("dts1", c1, 1);
    wr(4'h4, 16'h0000, 2'b01);
    for (i = 0; i < 6; i++) begin
      f = 4'(24'hFDBA63 >> (4 * i));
      d = fdiv_m(f) * flen_m(f);
      wr(4'h0, {f, 4'h2, f, 4'h1}, 2'b11);
      wr(4'h4, 16'h0003, 2'b01);
      c1 = 0;
      c2 = 0;
      pulse(3'b001, d - fdiv_m(f), 2 * d + 8);
      chk("flt_rej", c1 + c2, 0);
      pulse(3'b001, d, 2 * d + 8);
      chk("flt_acc1", c1, 1);
      chk("flt_acc2", c2, 1);
      wr(4'h4, 16'h0000, 2'b01);
    end
    wr(4'h8, 16'h0080, 2'b11);
    for (i = 0; i < 8; i++) begin
      v = $urandom;
      md = 3'h4 + i[1:0];
      cnt <= v[7:0] + 16'h0040;
      wr(4'h0, {1'b0, md, 1'b0, i[2], 10'h0}, 2'b11);
      repeat (4) @(posedge clk_i);
      chk("ref", ref_o, md == 5 || (md == 6 && cnt < cmp) || (md == 7 && cnt > cmp));
      chk("fen", fen, i[2]);
    end
    wr(4'h0, 16'hD000, 2'b11);
    etr <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("clr", ref_o, 0);
    etr <= 1'b0;
    cnt <= 16'h0100;
    wr(4'h0, 16'h6800, 2'b11);
    wr(4'h8, 16'h0200, 2'b11);
    repeat (4) @(posedge clk_i);
    chk("pre", ref_o, 0);
    upd <= 1'b1;
    @(posedge clk_i);
    upd <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("upd", ref_o, 1);
    rdc(4'h8, cmp);
    print_verdict;
  end
endmodule // ccr_ch12_mode_config_tb_top
`default_nettype wire
